// ==== padc_params.svh ====
// Constants for the pipelined converter digital face: mode codes, bias codes, latency and start-up counts.
// Assumes inclusion by bare name; holds definitions only.
// Notes on behaviour
// - Two mode pins pick active, standby, sleep, off.
// - Only active mode delivers valid words each cycle.
// - Bias pins scale current minus, plus, or typical.
// - Idle modes convert nothing; words marked invalid.
// - Start-up wait after idle, longest from power down.
// - Standby return needs eight cycles before valid.
// - Result is parallel twelve bits, MSB at top.
// - Offset binary: negative full scale zeros, positive ones.
// - Word appears six cycles after its sample.
// - In active mode every falling clock edge takes a new sample.
// - External reference select disables internal references.
`ifndef PADC_PARAMS_SVH
`define PADC_PARAMS_SVH
`define PADC_MODE_ACTIVE   2'h3
`define PADC_MODE_STANDBY  2'h2
`define PADC_MODE_SLEEP    2'h1
`define PADC_MODE_OFF      2'h0
`define PADC_BIAS_LOW      2'h2
`define PADC_BIAS_HIGH     2'h1
`define PADC_BIAS_TYP      2'h3
`define PADC_BIAS_UNDEF    2'h0
`define PADC_LATENCY       6
`define PADC_CLK_MHZ       100
`define PADC_START_STBY_CYC 8
`define PADC_START_SLEEP_US 2
`define PADC_START_OFF_US  1300
`define PADC_START_SLEEP_CYC (`PADC_START_SLEEP_US * `PADC_CLK_MHZ)
`define PADC_START_OFF_CYC (`PADC_START_OFF_US * `PADC_CLK_MHZ)
`endif

// ==== padc_pkg.sv ====
// Types shared by the converter digital face.
// Assumes the constants header is compiled alongside.
package padc_pkg;
  typedef enum logic [3:0] {
    PADC_ST_OFF     = 4'h1,
    PADC_ST_IDLE    = 4'h2,
    PADC_ST_WAKE    = 4'h4,
    PADC_ST_ACTIVE  = 4'h8
  } padc_state_e;
  typedef enum logic [1:0] {
    PADC_BIAS_SEL_TYP  = 2'h0,
    PADC_BIAS_SEL_LOW  = 2'h1,
    PADC_BIAS_SEL_HIGH = 2'h2,
    PADC_BIAS_SEL_BAD  = 2'h3
  } padc_bias_e;
  // One output word with its validity flag.
  typedef struct packed {
    logic        valid;
    logic [11:0] data;
  } padc_word_s;
  // Analog-side control levels.
  typedef struct packed {
    logic       core_enable;
    logic       ref_internal_enable;
    padc_bias_e bias;
  } padc_ctrl_s;
endpackage : padc_pkg

// ==== padc_delay_line.sv ====
// Fixed-latency word delay line clocked by the converter clock.
// Assumes one clock domain and an already synchronised reset.
`timescale 1ns/100ps
module padc_delay_line #(
  parameter int DEPTH = 6,
  parameter int WIDTH = 13
) (
  // Clock and reset.
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // Data.
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } padc_dl_s;
  padc_dl_s state;
  padc_dl_s next_state;
  // Shift one stage per cycle so a word leaves DEPTH cycles after entry.
  always_comb begin
    next_state = state;
    next_state.stage[0] = data_i;
    for (int i = 1; i < DEPTH; i++) begin
      next_state.stage[i] = state.stage[i-1];
    end
  end
  // Register the stages.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
  assign data_o = state.stage[DEPTH-1];
endmodule : padc_delay_line

// ==== padc_core.sv ====
// Digital face of a 12-bit pipelined converter: mode control, start-up wait, bias and reference control,
// sampling and fixed-latency result stream.
// Assumes sample_i arrives from the analog front end already quantised on the core clock.
`timescale 1ns/100ps
`include "padc_params.svh"
module padc_core #(
  parameter int LATENCY     = `PADC_LATENCY,
  parameter int STBY_CYC    = `PADC_START_STBY_CYC,
  parameter int SLEEP_CYC   = `PADC_START_SLEEP_CYC,
  parameter int OFF_CYC     = `PADC_START_OFF_CYC
) (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // Control pins from the outside party.
  input  wire logic [1:0]  operating_mode_select_i,
  input  wire logic [1:0]  bias_scale_i,
  input  wire logic        external_reference_select_i,
  // Quantised analog value from the front end.
  input  wire logic [11:0] sample_i,
  // Result stream.
  output logic [11:0]      conversion_result_o,
  output logic             result_valid_o,
  // Analog-side control.
  output logic             core_enable_o,
  output logic             ref_internal_enable_o,
  output logic [1:0]       bias_select_o,
  output logic             bias_pattern_error_o,
  output logic             converting_o
);
  // Reset release synchroniser.
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pin synchronisers for the control pins.
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {external_reference_select_i, bias_scale_i, operating_mode_select_i};
      pin_sync <= pin_meta;
    end
  end
  logic [1:0] mode;
  logic [1:0] bias_pins;
  logic       ext_ref;
  assign mode      = pin_sync[1:0];
  assign bias_pins = pin_sync[3:2];
  assign ext_ref   = pin_sync[4];

  // Start-up wait length depends on the idle mode that was left.
  function automatic logic [31:0] wake_len(input logic [1:0] m);
    case (m)
      `PADC_MODE_STANDBY: wake_len = 32'(STBY_CYC);
      `PADC_MODE_SLEEP:   wake_len = 32'(SLEEP_CYC);
      default:            wake_len = 32'(OFF_CYC);
    endcase
  endfunction

  // Bias pin decode.
  function automatic padc_pkg::padc_bias_e bias_dec(input logic [1:0] b);
    if (b == `PADC_BIAS_LOW) begin
      bias_dec = padc_pkg::PADC_BIAS_SEL_LOW;
    end else if (b == `PADC_BIAS_HIGH) begin
      bias_dec = padc_pkg::PADC_BIAS_SEL_HIGH;
    end else if (b == `PADC_BIAS_TYP) begin
      bias_dec = padc_pkg::PADC_BIAS_SEL_TYP;
    end else begin
      bias_dec = padc_pkg::PADC_BIAS_SEL_BAD;
    end
  endfunction

  typedef struct packed {
    padc_pkg::padc_state_e fsm;
    logic [1:0]            last_idle;
    logic [31:0]           count;
    logic [11:0]           sampled;
    logic                  sampled_valid;
    padc_pkg::padc_ctrl_s  ctrl;
    logic                  bias_err;
  } padc_core_s;
  padc_core_s state;
  padc_core_s next_state;

  // Mode state machine, sampling and analog control.
  always_comb begin
    next_state = state;
    next_state.sampled_valid = 1'b0;
    case (state.fsm)
      padc_pkg::PADC_ST_OFF: begin
        next_state.last_idle = `PADC_MODE_OFF;
        if (mode != `PADC_MODE_OFF) begin
          next_state.fsm = (mode == `PADC_MODE_ACTIVE) ? padc_pkg::PADC_ST_WAKE : padc_pkg::PADC_ST_IDLE;
          next_state.count = wake_len(`PADC_MODE_OFF);
        end
      end
      padc_pkg::PADC_ST_IDLE: begin
        next_state.last_idle = mode;
        if (mode == `PADC_MODE_OFF) begin
          next_state.fsm = padc_pkg::PADC_ST_OFF;
        end else if (mode == `PADC_MODE_ACTIVE) begin
          next_state.fsm = padc_pkg::PADC_ST_WAKE;
          next_state.count = wake_len(state.last_idle);
        end
      end
      padc_pkg::PADC_ST_WAKE: begin
        if (mode != `PADC_MODE_ACTIVE) begin
          next_state.fsm = (mode == `PADC_MODE_OFF) ? padc_pkg::PADC_ST_OFF : padc_pkg::PADC_ST_IDLE;
          next_state.last_idle = mode;
        end else if (state.count <= 32'h00000001) begin
          next_state.fsm = padc_pkg::PADC_ST_ACTIVE;
          next_state.count = 32'h00000000;
        end else begin
          next_state.count = state.count - 32'h00000001;
        end
      end
      padc_pkg::PADC_ST_ACTIVE: begin
        if (mode != `PADC_MODE_ACTIVE) begin
          next_state.fsm = (mode == `PADC_MODE_OFF) ? padc_pkg::PADC_ST_OFF : padc_pkg::PADC_ST_IDLE;
          next_state.last_idle = mode;
        end
      end
      default: begin
        next_state.fsm = padc_pkg::PADC_ST_OFF;
      end
    endcase
    // A sample is taken every cycle in active mode; idle modes convert nothing.
    if (state.fsm == padc_pkg::PADC_ST_ACTIVE && mode == `PADC_MODE_ACTIVE) begin
      next_state.sampled = sample_i;
      next_state.sampled_valid = 1'b1;
    end
    next_state.ctrl.core_enable = (mode == `PADC_MODE_ACTIVE);
    next_state.ctrl.ref_internal_enable = !ext_ref;
    next_state.ctrl.bias = bias_dec(bias_pins);
    next_state.bias_err = (bias_pins == `PADC_BIAS_UNDEF);
  end

  // Sample register runs on the falling edge so each falling edge in active mode starts a conversion.
  always_ff @(negedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= padc_core_s'({padc_pkg::PADC_ST_OFF, 52'h0}); // Off state, every other field cleared.
    end else begin
      state <= next_state;
    end
  end

  // Fixed latency from sample to output word.
  padc_pkg::padc_word_s word_out;
  padc_delay_line #(
    .DEPTH (LATENCY),
    .WIDTH (13)
  ) u_delay (
    .clock_i (clock_i),
    .rstn_i  (rst_sync),
    .data_i  ({state.sampled_valid, state.sampled}),
    .data_o  (word_out)
  );

  // Outputs; invalid words are forced to zero so stale data never leaks.
  assign conversion_result_o   = word_out.valid ? word_out.data : 12'h000;
  assign result_valid_o        = word_out.valid;
  assign core_enable_o         = state.ctrl.core_enable;
  assign ref_internal_enable_o = state.ctrl.ref_internal_enable;
  assign bias_select_o         = state.ctrl.bias;
  assign bias_pattern_error_o  = state.bias_err;
  assign converting_o          = (state.fsm == padc_pkg::PADC_ST_ACTIVE);
endmodule : padc_core

// ==== padc_sva.sv ====
// Checker for the converter digital face; sees only the core's ports.
// Assumes one clock domain and the core's active-low reset.
`timescale 1ns/100ps
module padc_sva #(
  parameter int OFF_CYC = 20
) (
  // Clock, reset and control pins.
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [1:0]  operating_mode_select_i,
  input wire logic [1:0]  bias_scale_i,
  input wire logic        external_reference_select_i,
  input wire logic [11:0] sample_i,
  // Outputs of the core.
  input wire logic [11:0] conversion_result_o,
  input wire logic        result_valid_o,
  input wire logic        core_enable_o,
  input wire logic        ref_internal_enable_o,
  input wire logic [1:0]  bias_select_o,
  input wire logic        bias_pattern_error_o,
  input wire logic        converting_o
);
  logic [17:0] idle_cnt;
  logic [17:0] act_cnt;
  logic [17:0] stby_cnt;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Counts cycles spent without a break in idle and in active mode.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt <= 18'h00000;
      act_cnt  <= 18'h00000;
      stby_cnt <= 18'h00000;
    end else begin
      idle_cnt <= (operating_mode_select_i == 2'h3) ? 18'h00000 : idle_cnt + 18'h00001;
      act_cnt  <= (operating_mode_select_i == 2'h3) ? act_cnt + 18'h00001 : 18'h00000;
      stby_cnt <= (operating_mode_select_i == 2'h2) ? stby_cnt + 18'h00001 : 18'h00000;
    end
  end
  sequence s_stby_held;
    stby_cnt >= 4 && operating_mode_select_i == 2'h2;
  endsequence
  sequence s_go_active;
    operating_mode_select_i == 2'h3;
  endsequence
  // Active held without a break since the wake request, fifteen samples in all.
  sequence s_act_held;
    act_cnt >= 14 && operating_mode_select_i == 2'h3;
  endsequence
  a_stby_wait_low: assert property (s_stby_held ##1 s_go_active |-> (!converting_o)[*8])
    else $error("Converting before standby start-up ended");
  a_stby_wake_up: assert property (s_stby_held ##1 s_go_active ##14 s_act_held |-> converting_o)
    else $error("No conversion after standby start-up");
  a_idle_no_word: assert property (idle_cnt >= 12 |-> !result_valid_o)
    else $error("Valid word while idle");
  a_idle_no_conv: assert property (idle_cnt >= 5 |-> !converting_o && !core_enable_o)
    else $error("Core running while idle");
  a_invalid_zero: assert property (!result_valid_o |-> conversion_result_o == 12'h000)
    else $error("Invalid word not zero");
  a_active_stream: assert property (act_cnt >= OFF_CYC + 16 |-> result_valid_o && converting_o)
    else $error("Active mode without valid words");
  a_bias_low_sel: assert property ((bias_scale_i == 2'h2)[*6] |-> bias_select_o == padc_pkg::PADC_BIAS_SEL_LOW)
    else $error("Bias low not selected");
  a_bias_high_sel: assert property ((bias_scale_i == 2'h1)[*6] |->
    bias_select_o == padc_pkg::PADC_BIAS_SEL_HIGH)
    else $error("Bias high not selected");
  a_bias_bad_flag: assert property ((bias_scale_i == 2'h0)[*6] |-> bias_pattern_error_o)
    else $error("Bias pattern zero not flagged");
  a_ext_ref_off: assert property (external_reference_select_i[*6] |-> !ref_internal_enable_o)
    else $error("Internal reference left on");
endmodule : padc_sva
bind padc_core padc_sva #(.OFF_CYC(OFF_CYC)) u_sva (
  .clock_i(clock_i), .rstn_i(rstn_i), .operating_mode_select_i(operating_mode_select_i),
  .bias_scale_i(bias_scale_i), .external_reference_select_i(external_reference_select_i),
  .sample_i(sample_i), .conversion_result_o(conversion_result_o), .result_valid_o(result_valid_o),
  .core_enable_o(core_enable_o), .ref_internal_enable_o(ref_internal_enable_o),
  .bias_select_o(bias_select_o), .bias_pattern_error_o(bias_pattern_error_o), .converting_o(converting_o));

// ==== padc_soc_cap.sv ====
// Capture side of the result stream: latches each word on the falling edge.
// Assumes the core registers its words on the rising edge.
`timescale 1ns/100ps
module padc_soc_cap (
  // Clock and stream in.
  input  wire logic        clock_i,
  input  wire logic [11:0] word_i,
  input  wire logic        valid_i,
  // Captured word.
  output logic      [11:0] cap_word_o,
  output logic             cap_valid_o
);
  // Invalid cycles show an inverted stale word, so a dropped word never matches by chance.
  always_ff @(negedge clock_i) begin
    cap_valid_o <= valid_i;
    cap_word_o  <= valid_i ? word_i : ~cap_word_o;
  end
endmodule : padc_soc_cap

// ==== padc_core_tb.sv ====
// Bench for the converter digital face: bias, reference, mode start-up and result stream.
// Assumes the core, its checker and the capture model are compiled first.
`timescale 1ns/100ps
module padc_core_tb;
  localparam int OFF = 20;
  localparam int SLP = 10;
  logic              clock_i = 1'b0;
  logic              rstn_i  = 1'b0;
  logic [1:0]        mode    = 2'h0;
  logic [1:0]        bias    = 2'h3;
  logic              ext     = 1'b0;
  logic [11:0]       smp     = 12'h000;
  logic [11:0]       res;
  logic [11:0]       cword;
  logic [1:0]        bsel;
  logic              vld, cen, rie, berr, conv, cvld;
  logic [11:0]       hist[$];
  logic [1:0]        idle_m[3] = '{2'h0, 2'h1, 2'h2};
  int                lo_c[3]   = '{OFF, SLP, 8};
  padc_pkg::padc_bias_e bexp[4] = '{padc_pkg::PADC_BIAS_SEL_BAD, padc_pkg::PADC_BIAS_SEL_HIGH,
                                    padc_pkg::PADC_BIAS_SEL_LOW, padc_pkg::PADC_BIAS_SEL_TYP};
  int                err_total = 0;
  int                cmp_count = 0;
  int                cyc       = 0;
  // Free-running converter clock.
  initial forever #5 clock_i = ~clock_i;
  // Hang guard.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  padc_core #(.OFF_CYC(OFF), .SLEEP_CYC(SLP)) DUT (
    .clock_i(clock_i), .rstn_i(rstn_i), .operating_mode_select_i(mode), .bias_scale_i(bias),
    .external_reference_select_i(ext), .sample_i(smp), .conversion_result_o(res),
    .result_valid_o(vld), .core_enable_o(cen), .ref_internal_enable_o(rie),
    .bias_select_o(bsel), .bias_pattern_error_o(berr), .converting_o(conv));
  padc_soc_cap u_cap (.clock_i(clock_i), .word_i(res), .valid_i(vld), .cap_word_o(cword), .cap_valid_o(cvld));
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wt
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // Main sequence: bias table, reference select, then each idle mode back to active.
  initial begin
    wt(3);
    rstn_i = 1'b1;
    wt(4);
    for (int b = 0; b < 4; b++) begin
      bias = 2'(b);
      wt(6);
      chk("bias_sel", 16'(bsel), 16'(bexp[b]));
      chk("bias_err", 16'(berr), 16'(b == 0));
    end
    for (int e = 0; e < 2; e++) begin
      ext = ~e[0];
      wt(6);
      chk("ref_int", 16'(rie), 16'(!ext));
    end
    for (int m = 0; m < 3; m++) begin
      mode = idle_m[m];
      wt(20);
      chk("idle_out", {1'b0, vld, cen, conv, res}, 16'h0000);
      mode = 2'h3;
      wt(lo_c[m]);
      chk("early_conv", 16'(conv), 16'h0000);
      wt(7);
      chk("late_conv", 16'({cen, conv}), 16'h0003);
      wt(8);
      // The ramp reaches both the all-zeros and the all-ones code.
      for (int i = 0; i < 22; i++) begin
        smp = 12'(i * 273);
        @(negedge clock_i);
        #1;
        if (hist.size() >= 6) chk("word", {3'h0, cvld, cword}, {4'h1, hist[5]});
        hist.push_front(smp);
        wt(1);
      end
      hist.delete();
    end
    finish_test();
  end
endmodule : padc_core_tb
